// file: shared/dtsc_pkg.sv
// Shared constants and types for the door terminal switch configuration block
package dtsc_pkg;

	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned SETTLE_US     = 10;
	localparam int unsigned SETTLE_CYC    = (CLK_HZ / 1_000_000) * SETTLE_US;
	localparam int unsigned BEEP_ON_MS    = 100;
	localparam int unsigned BEEP_OFF_MS   = 100;
	localparam int unsigned BEEP_GAP_MS   = 1000;
	localparam int unsigned BEEP_ON_CYC   = (CLK_HZ / 1000) * BEEP_ON_MS;
	localparam int unsigned BEEP_OFF_CYC  = (CLK_HZ / 1000) * BEEP_OFF_MS;
	localparam int unsigned BEEP_GAP_CYC  = (CLK_HZ / 1000) * BEEP_GAP_MS;
	localparam int          TIMER_W       = 26;

	// ==========================================================
	// Switch field positions
	localparam int SWA_BAUD_LO = 0;
	localparam int SWA_BAUD_HI = 1;
	localparam int SWA_SIMUL   = 2;
	localparam int SWA_TEST    = 3;
	localparam int SWB_ADDR_LO = 0;
	localparam int SWB_ADDR_HI = 1;

	// ==========================================================
	// Digital input positions (input 3 and 4)
	localparam int DIN_INSIDE  = 2;
	localparam int DIN_OUTSIDE = 3;

	// ==========================================================
	// Link framing and rates
	localparam logic [3:0]  FRAME_DATA_BITS = 4'h8;
	localparam logic        FRAME_PARITY_EN = 1'h0;
	localparam logic [1:0]  FRAME_STOP_BITS = 2'h1;
	localparam logic [15:0] DIV_19200       = 16'(CLK_HZ / 19200);
	localparam logic [15:0] DIV_9600        = 16'(CLK_HZ / 9600);
	localparam logic [15:0] DIV_4800        = 16'(CLK_HZ / 4800);
	localparam logic [15:0] DIV_2400        = 16'(CLK_HZ / 2400);

	// ==========================================================
	// Beep codes and reset values
	localparam logic [2:0] BEEPS_INSIDE  = 3'h2;
	localparam logic [2:0] BEEPS_OUTSIDE = 3'h3;
	localparam logic [2:0] BEEPS_TAMPER  = 3'h5;
	localparam logic [2:0] ADDR_BASE     = 3'h1;
	localparam logic [1:0] BAUD_RST      = 2'h0;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic        test_mode;
		logic        simul_mode;
		logic [1:0]  baud_code;
		logic [2:0]  door_addr;
	} dtsc_cfg_t;

	typedef struct packed {
		logic [15:0] baud_div;
		logic [3:0]  data_bits;
		logic        parity_en;
		logic [1:0]  stop_bits;
	} dtsc_link_t;

endpackage

// file: verilog/dtsc_beep.sv
// Beep code sequencer: N beeps followed by a silent gap
`timescale 1ns/1ps
module dtsc_beep #(
	parameter int unsigned ON_CYC  = dtsc_pkg::BEEP_ON_CYC,
	parameter int unsigned OFF_CYC = dtsc_pkg::BEEP_OFF_CYC,
	parameter int unsigned GAP_CYC = dtsc_pkg::BEEP_GAP_CYC
) (
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic       start,
	input  wire logic [2:0] beeps,
	output logic            busy,
	output logic            tone
);
	import dtsc_pkg::*;

	typedef enum logic [1:0] {
		BP_IDLE = 2'b00,
		BP_ON   = 2'b01,
		BP_OFF  = 2'b10,
		BP_GAP  = 2'b11
	} dtsc_bp_t;

	typedef struct packed {
		dtsc_bp_t           st;
		logic [2:0]         left;
		logic [TIMER_W-1:0] tmr;
		logic               tone;
	} dtsc_bs_t;

	dtsc_bs_t s_r;
	dtsc_bs_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			BP_IDLE: begin
				if (start && beeps != 3'h0) begin
					s_nxt.st   = BP_ON;
					s_nxt.left = beeps;
					s_nxt.tmr  = TIMER_W'(ON_CYC - 1);
					s_nxt.tone = 1'b1;
				end
			end
			BP_ON: begin
				if (s_r.tmr == '0) begin
					s_nxt.left = s_r.left - 3'h1;
					s_nxt.tone = 1'b0;
					s_nxt.st   = (s_r.left == 3'h1) ? BP_GAP : BP_OFF;
					s_nxt.tmr  = (s_r.left == 3'h1) ? TIMER_W'(GAP_CYC - 1) : TIMER_W'(OFF_CYC - 1);
				end else begin
					s_nxt.tmr = s_r.tmr - 1'b1;
				end
			end
			BP_OFF: begin
				if (s_r.tmr == '0) begin
					s_nxt.st   = BP_ON;
					s_nxt.tmr  = TIMER_W'(ON_CYC - 1);
					s_nxt.tone = 1'b1;
				end else begin
					s_nxt.tmr = s_r.tmr - 1'b1;
				end
			end
			// Gap keeps successive codes distinguishable
			BP_GAP: begin
				if (s_r.tmr == '0) begin
					s_nxt.st = BP_IDLE;
				end else begin
					s_nxt.tmr = s_r.tmr - 1'b1;
				end
			end
			default: begin
				s_nxt.st = BP_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_r <= '{st: BP_IDLE, left: 3'h0, tmr: '0, tone: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign busy = (s_r.st != BP_IDLE);
	assign tone = s_r.tone;

endmodule

// file: verilog/dtsc_top.sv
// Door terminal power-up configuration, scanner gating and beep codes
`timescale 1ns/1ps
module dtsc_top #(
	parameter int unsigned BEEP_ON_CYC  = dtsc_pkg::BEEP_ON_CYC,
	parameter int unsigned BEEP_OFF_CYC = dtsc_pkg::BEEP_OFF_CYC,
	parameter int unsigned BEEP_GAP_CYC = dtsc_pkg::BEEP_GAP_CYC
) (
	input  wire logic         sys_clk,
	input  wire logic         nrst,
	input  wire logic [3:0]   option_switch_bank_a,
	input  wire logic [3:0]   option_switch_bank_b,
	input  wire logic [3:0]   digital_in,
	input  wire logic         tamper_open,
	input  wire logic         scan_disable_mode,
	input  wire logic         internal_tag,
	input  wire logic         shared_reader_port_tag,
	input  wire logic         second_reader_port_tag,
	input  wire logic         entry_req,
	input  wire logic         exit_req,
	input  wire logic         door_cycle_done,
	output dtsc_pkg::dtsc_cfg_t  cfg,
	output dtsc_pkg::dtsc_link_t link_cfg,
	output logic              cfg_valid,
	output logic [1:0]        scan_tag,
	output logic              entry_grant,
	output logic              exit_grant,
	output logic              tamper_alarm,
	output logic              buzzer
);
	import dtsc_pkg::*;

	// ==========================================================
	// State
	typedef enum logic [1:0] {
		TS_SETTLE = 2'b00,
		TS_RUN    = 2'b01
	} dtsc_ts_t;

	typedef struct packed {
		dtsc_ts_t    st;
		logic [9:0]  settle;
		dtsc_cfg_t   cfg;
		dtsc_link_t  link;
		logic        valid;
		logic [1:0]  scan_tag;
		logic        entry_grant;
		logic        exit_grant;
		logic        cycle_busy;
		logic        tamper_d;
		logic        tamper_pend;
		logic        in_pend;
		logic        out_pend;
		logic        start;
		logic [2:0]  beeps;
		logic        buzzer;
	} dtsc_state_t;

	dtsc_state_t s_r;
	dtsc_state_t s_nxt;
	logic        bp_busy;
	logic        bp_tone;
	logic        inside_open;
	logic        outside_open;
	logic [1:0]  ch_ok;
	logic [1:0]  ch_tag;

	// ==========================================================
	// Beep sequencer
	dtsc_beep #(
		.ON_CYC  (BEEP_ON_CYC),
		.OFF_CYC (BEEP_OFF_CYC),
		.GAP_CYC (BEEP_GAP_CYC)
	) u_beep (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.start   (s_r.start),
		.beeps   (s_r.beeps),
		.busy    (bp_busy),
		.tone    (bp_tone)
	);

	// ==========================================================
	// Input qualification
	// open contact is high
	assign inside_open  = digital_in[DIN_INSIDE]  & ~scan_disable_mode;
	assign outside_open = digital_in[DIN_OUTSIDE] & ~scan_disable_mode;
	assign ch_tag[0] = internal_tag | shared_reader_port_tag;
	assign ch_tag[1] = second_reader_port_tag;
	// scanner one needs input 3 low
	assign ch_ok[0]  = ~scan_disable_mode | ~digital_in[DIN_INSIDE];
	// scanner two needs input 4 low
	assign ch_ok[1]  = ~scan_disable_mode | ~digital_in[DIN_OUTSIDE];

	// ==========================================================
	// Next state
	always_comb begin
		s_nxt       = s_r;
		s_nxt.start = 1'b0;
		s_nxt.entry_grant = 1'b0;
		s_nxt.exit_grant  = 1'b0;
		case (s_r.st)
			// Settle lets switch contacts stop bouncing after power-up
			TS_SETTLE: begin
				if (s_r.settle == 10'(SETTLE_CYC - 1)) begin
					s_nxt.st             = TS_RUN;
					s_nxt.valid          = 1'b1;
					s_nxt.cfg.baud_code  = {option_switch_bank_a[SWA_BAUD_HI], option_switch_bank_a[SWA_BAUD_LO]};
					s_nxt.cfg.simul_mode = option_switch_bank_a[SWA_SIMUL];
					s_nxt.cfg.test_mode  = option_switch_bank_a[SWA_TEST];
					s_nxt.cfg.door_addr  = ADDR_BASE
						+ {1'b0, option_switch_bank_b[SWB_ADDR_HI], option_switch_bank_b[SWB_ADDR_LO]};
					case ({option_switch_bank_a[SWA_BAUD_HI], option_switch_bank_a[SWA_BAUD_LO]})
						2'b00: s_nxt.link.baud_div = DIV_19200;
						2'b01: s_nxt.link.baud_div = DIV_9600;
						2'b10: s_nxt.link.baud_div = DIV_4800;
						default: s_nxt.link.baud_div = DIV_2400;
					endcase
				end else begin
					s_nxt.settle = s_r.settle + 10'h1;
				end
			end
			TS_RUN: begin
				s_nxt.scan_tag = ch_tag & ch_ok;

				if (s_r.cfg.simul_mode) begin
					s_nxt.entry_grant = entry_req;
					s_nxt.exit_grant  = exit_req;
				end else if (!s_r.cycle_busy && (entry_req ^ exit_req)) begin
					s_nxt.entry_grant = entry_req;
					s_nxt.exit_grant  = exit_req;
					s_nxt.cycle_busy  = 1'b1;
				end else if (door_cycle_done) begin
					s_nxt.cycle_busy  = 1'b0;
				end

				s_nxt.tamper_d = tamper_open;
				s_nxt.in_pend  = s_r.in_pend | inside_open;
				s_nxt.out_pend = s_r.out_pend | outside_open;

				// tamper wins, one code at a time
				if (!bp_busy && !s_r.start && !s_r.cfg.test_mode) begin
					if (s_r.tamper_pend) begin
						s_nxt.start = 1'b1;
						s_nxt.beeps = BEEPS_TAMPER;
						s_nxt.tamper_pend = 1'b0;
					end else if (s_r.in_pend) begin
						s_nxt.start = 1'b1;
						s_nxt.beeps = BEEPS_INSIDE;
						s_nxt.in_pend = inside_open;
					end else if (s_r.out_pend) begin
						s_nxt.start = 1'b1;
						s_nxt.beeps = BEEPS_OUTSIDE;
						s_nxt.out_pend = outside_open;
					end
				end
				// Set wins over the clear above
				if (tamper_open && !s_r.tamper_d) begin
					s_nxt.tamper_pend = 1'b1;
				end

				// test mode buzzes while a tag sits
				s_nxt.buzzer = s_r.cfg.test_mode ? (|ch_tag) : bp_tone;
			end
			default: begin
				s_nxt.st = TS_SETTLE;
			end
		endcase
	end

	// ==========================================================
	// State register
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_r <= '{
				st:          TS_SETTLE,
				settle:      10'h000,
				cfg:         '{test_mode: 1'b0, simul_mode: 1'b0, baud_code: BAUD_RST, door_addr: ADDR_BASE},
				link:        '{baud_div: DIV_19200, data_bits: FRAME_DATA_BITS,
				               parity_en: FRAME_PARITY_EN, stop_bits: FRAME_STOP_BITS},
				valid:       1'b0,
				scan_tag:    2'h0,
				entry_grant: 1'b0,
				exit_grant:  1'b0,
				cycle_busy:  1'b0,
				tamper_d:    1'b0,
				tamper_pend: 1'b0,
				in_pend:     1'b0,
				out_pend:    1'b0,
				start:       1'b0,
				beeps:       3'h0,
				buzzer:      1'b0
			};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign cfg          = s_r.cfg;
	assign link_cfg     = s_r.link;
	assign cfg_valid    = s_r.valid;
	assign scan_tag     = s_r.scan_tag;
	assign entry_grant  = s_r.entry_grant;
	assign exit_grant   = s_r.exit_grant;
	assign tamper_alarm = s_r.tamper_d;
	assign buzzer       = s_r.buzzer;

endmodule

// file: testbench/dtsc_ctrl_model.sv
// Access controller model: scanner-disable choice and framing check
`timescale 1ns/1ps
module dtsc_ctrl_model (
	input  wire logic                 sys_clk,
	input  wire logic                 want_disable,
	input  wire dtsc_pkg::dtsc_link_t link_cfg,
	output logic                      scan_disable_mode,
	output logic                      frame_ok
);
	import dtsc_pkg::*;
	// ==========================================================
	// Controller side
	// controller owns choice
	always_ff @(posedge sys_clk) begin
		scan_disable_mode <= want_disable;
	end
	assign frame_ok = (link_cfg.data_bits == 4'h8) && !link_cfg.parity_en && (link_cfg.stop_bits == 2'h1);
endmodule

// file: testbench/dtsc_top_assertions.sv
// Port assertions for the door terminal configuration block
`timescale 1ns/1ps
module dtsc_top_assertions #(
	parameter int unsigned BEEP_ON_CYC  = 4,
	parameter int unsigned BEEP_OFF_CYC = 3,
	parameter int unsigned BEEP_GAP_CYC = 10
) (
	input wire logic                 sys_clk,
	input wire logic                 nrst,
	input wire logic [3:0]           option_switch_bank_a,
	input wire logic [3:0]           option_switch_bank_b,
	input wire logic [3:0]           digital_in,
	input wire logic                 tamper_open,
	input wire logic                 scan_disable_mode,
	input wire logic                 entry_req,
	input wire logic                 exit_req,
	input wire dtsc_pkg::dtsc_cfg_t  cfg,
	input wire dtsc_pkg::dtsc_link_t link_cfg,
	input wire logic                 cfg_valid,
	input wire logic [1:0]           scan_tag,
	input wire logic                 entry_grant,
	input wire logic                 exit_grant,
	input wire logic                 tamper_alarm,
	input wire logic                 buzzer
);
	import dtsc_pkg::*;
	localparam logic [15:0] DIVS [4] = '{DIV_19200, DIV_9600, DIV_4800, DIV_2400};
	logic [25:0] on_cnt_r;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// ==========================================================
	// Helper: length of the current tone
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			on_cnt_r <= 26'h0;
		end else begin
			on_cnt_r <= buzzer ? on_cnt_r + 26'h1 : 26'h0;
		end
	end
	sequence s_take;
		$rose(cfg_valid);
	endsequence
	sequence s_tamper_edge;
		$rose(tamper_open) && cfg_valid && !cfg.test_mode;
	endsequence
	// ==========================================================
	// Properties
	property p_hold;
		cfg_valid |=> cfg_valid && $stable(cfg) && $stable(link_cfg);
	endproperty
	property p_addr;
		s_take |-> cfg.door_addr == ADDR_BASE + 3'($past(option_switch_bank_b[1:0]));
	endproperty
	property p_baud;
		s_take |-> cfg.baud_code == $past(option_switch_bank_a[1:0])
			&& link_cfg.baud_div == DIVS[$past(option_switch_bank_a[1:0])];
	endproperty
	property p_frame;
		cfg_valid |-> link_cfg.data_bits == 4'h8 && !link_cfg.parity_en && link_cfg.stop_bits == 2'h1;
	endproperty
	property p_gate0;
		scan_disable_mode && digital_in[DIN_INSIDE] |=> !scan_tag[0];
	endproperty
	property p_gate1;
		scan_disable_mode && digital_in[DIN_OUTSIDE] |=> !scan_tag[1];
	endproperty
	property p_tamper;
		cfg_valid && tamper_open |=> tamper_alarm;
	endproperty
	property p_cycled;
		cfg_valid && !cfg.simul_mode && entry_req && exit_req |=> !entry_grant && !exit_grant;
	endproperty
	property p_on_len;
		$fell(buzzer) && !cfg.test_mode |-> on_cnt_r == 26'(BEEP_ON_CYC);
	endproperty
	property p_tamper_beep;
		s_tamper_edge |-> ##[1:80] buzzer;
	endproperty
	a_hold: assert property (p_hold) else $error("config moved");
	a_addr: assert property (p_addr) else $error("door address wrong");
	a_baud: assert property (p_baud) else $error("link rate wrong");
	a_frame: assert property (p_frame) else $error("framing wrong");
	a_gate0: assert property (p_gate0) else $error("channel one not gated");
	a_gate1: assert property (p_gate1) else $error("channel two not gated");
	a_tamper: assert property (p_tamper) else $error("tamper missed");
	a_cycled: assert property (p_cycled) else $error("concurrent grant");
	a_on_len: assert property (p_on_len) else $error("tone length wrong");
	a_tamper_beep: assert property (p_tamper_beep) else $error("tamper silent");
endmodule
bind dtsc_top dtsc_top_assertions #(.BEEP_ON_CYC(BEEP_ON_CYC), .BEEP_OFF_CYC(BEEP_OFF_CYC),
	.BEEP_GAP_CYC(BEEP_GAP_CYC)) chk_u (.sys_clk(sys_clk), .nrst(nrst),
	.option_switch_bank_a(option_switch_bank_a), .option_switch_bank_b(option_switch_bank_b),
	.digital_in(digital_in), .tamper_open(tamper_open), .scan_disable_mode(scan_disable_mode),
	.entry_req(entry_req), .exit_req(exit_req), .cfg(cfg), .link_cfg(link_cfg), .cfg_valid(cfg_valid),
	.scan_tag(scan_tag), .entry_grant(entry_grant), .exit_grant(exit_grant),
	.tamper_alarm(tamper_alarm), .buzzer(buzzer));

// file: testbench/dtsc_top_tb.sv
// Self-checking bench for the door terminal configuration block
`timescale 1ns/1ps
`define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin err_count++; $display("mismatch %0t %s", $time, m); end end
module dtsc_top_tb;
	import dtsc_pkg::*;
	logic       sys_clk, nrst, tamper, want_dis, dis, frame_ok, ti, ts, t2, er, xr, done;
	logic [3:0] sa, sb, din;
	logic       cfg_valid, eg, xg, alarm, buzzer;
	logic [1:0] scan_tag;
	dtsc_cfg_t  cfg;
	dtsc_link_t link;
	int         err_count, checked, cyc, n, i;
	int         rates [4] = '{19200, 9600, 4800, 2400};
	dtsc_top #(.BEEP_ON_CYC(4), .BEEP_OFF_CYC(3), .BEEP_GAP_CYC(10)) dut_u (.sys_clk(sys_clk), .nrst(nrst),
		.option_switch_bank_a(sa), .option_switch_bank_b(sb), .digital_in(din), .tamper_open(tamper),
		.scan_disable_mode(dis), .internal_tag(ti), .shared_reader_port_tag(ts), .second_reader_port_tag(t2),
		.entry_req(er), .exit_req(xr), .door_cycle_done(done), .cfg(cfg), .link_cfg(link),
		.cfg_valid(cfg_valid), .scan_tag(scan_tag), .entry_grant(eg), .exit_grant(xg),
		.tamper_alarm(alarm), .buzzer(buzzer));
	dtsc_ctrl_model ctrl_u (.sys_clk(sys_clk), .want_disable(want_dis), .link_cfg(link),
		.scan_disable_mode(dis), .frame_ok(frame_ok));
	// ==========================================================
	// Clock, timeout and verdict
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 12000) begin
			err_count++;
			summarize();
		end
	end
	task summarize;
		if (err_count == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// ==========================================================
	// Access tasks
	task pwr(input logic [3:0] a, input logic [3:0] b);
		@(posedge sys_clk);
		nrst <= 1'h0;
		sa <= a;
		sb <= b;
		repeat (16) @(posedge sys_clk);
		nrst <= 1'h1;
		repeat (501) @(posedge sys_clk);
		#1;
	endtask
	task req(input logic e, input logic x, input logic d, input logic ge, input logic gx);
		@(posedge sys_clk);
		er <= e;
		xr <= x;
		done <= d;
		@(posedge sys_clk);
		er <= 1'h0;
		xr <= 1'h0;
		done <= 1'h0;
		#1;
		`CHK({eg, xg}, {ge, gx}, "grant")
	endtask
	task scan(input logic [3:0] d, input logic [2:0] t, input logic m, input logic [1:0] e);
		@(posedge sys_clk);
		din <= d;
		{t2, ts, ti} <= t;
		want_dis <= m;
		repeat (3) @(posedge sys_clk);
		#1;
		`CHK(scan_tag, e, "scan")
	endtask
	// Eight quiet cycles end a code; the short silence between beeps does not
	task beeps(output int cnt);
		int  lo;
		logic p;
		cnt = 0;
		p = 1'h0;
		for (lo = 0; lo < 300 && buzzer !== 1'h1; lo++) begin
			@(posedge sys_clk);
			#1;
		end
		lo = 0;
		while (lo < 8) begin
			if (buzzer === 1'h1 && !p) cnt++;
			lo = (buzzer === 1'h1) ? 0 : lo + 1;
			p = (buzzer === 1'h1);
			@(posedge sys_clk);
			#1;
		end
	endtask
	// ==========================================================
	// Tests
	initial begin
		{sys_clk, nrst, tamper, want_dis, ti, ts, t2, er, xr, done} = 10'h0;
		{sa, sb, din} = 12'h0;
		// Bank B bits 3 and 4 always off
		for (i = 0; i < 4; i++) begin
			pwr(4'(i) | 4'h4, 4'(i));
			`CHK(cfg_valid, 1'h1, "valid")
			`CHK(cfg.baud_code, 2'(i), "rate code")
			`CHK(link.baud_div, 16'(CLK_HZ / rates[i]), "divisor")
			`CHK(cfg.door_addr, 3'(i + 1), "address")
			`CHK(frame_ok, 1'h1, "framing")
			`CHK({cfg.test_mode, cfg.simul_mode}, 2'h1, "mode bits")
			@(posedge sys_clk);
			sa <= 4'(3 - i);
			sb <= 4'(3 - i);
			repeat (20) @(posedge sys_clk);
			#1;
			`CHK({cfg.baud_code, cfg.door_addr}, {2'(i), 3'(i + 1)}, "latched")
		end
		req(1'h1, 1'h1, 1'h0, 1'h1, 1'h1);
		scan(4'hC, 3'h5, 1'h1, 2'h0);
		scan(4'h4, 3'h5, 1'h1, 2'h2);
		scan(4'h8, 3'h6, 1'h1, 2'h1);
		scan(4'h0, 3'h4, 1'h0, 2'h2);
		scan(4'h0, 3'h0, 1'h0, 2'h0);
		pwr(4'h0, 4'h0);
		`CHK({cfg.test_mode, cfg.simul_mode}, 2'h0, "cycled latch")
		req(1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
		req(1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
		req(1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
		req(1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
		req(1'h0, 1'h1, 1'h0, 1'h0, 1'h1);
		@(posedge sys_clk);
		tamper <= 1'h1;
		din <= 4'h4;
		beeps(n);
		`CHK(n, 5, "tamper first")
		beeps(n);
		`CHK(n, 2, "inside code")
		beeps(n);
		`CHK(n, 2, "code repeats")
		`CHK(alarm, 1'h1, "alarm")
		@(posedge sys_clk);
		din <= 4'h8;
		beeps(n);
		`CHK(n, 2, "last inside code")
		beeps(n);
		`CHK(n, 3, "outside code")
		pwr(4'h8, 4'h0);
		`CHK({cfg.test_mode, cfg.simul_mode}, 2'h2, "test latch")
		scan(4'h0, 3'h1, 1'h0, 2'h1);
		`CHK(buzzer, 1'h1, "test buzz")
		scan(4'h0, 3'h0, 1'h0, 2'h0);
		`CHK(buzzer, 1'h0, "test quiet")
		summarize();
	end
endmodule
